//--- design/dfpp_link.sv
// dfpp_link: bit-level engine of the two-wire debug link.
// assumes: link clock and data pins are asynchronous; the host changes data while clock is low.
`timescale 1ns/1ps
`default_nettype none
module dfpp_link import dfpp_pkg::*; (
  // clock and reset
  input  wire logic      i_clock,
  input  wire logic      i_rst,
  // pins
  input  wire logic      i_link_clk_pin,
  input  wire logic      i_link_data_pin,
  // read sources
  input  wire logic [7:0] i_addr_byte,
  input  wire logic [7:0] i_data_byte,
  // events, pin drive and synchronized pin levels
  output dfpp_evt_t      o_evt,
  output logic           o_evt_valid,
  output logic           o_data_out,
  output logic           o_data_oe,
  output logic           o_clk_lvl,
  output logic           o_data_lvl
);

  logic ck_s1_q, ck_s2_q, ck_s3_q, d_s1_q, d_s2_q;
  logic rise, fall;
  dfpp_lk_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] op_q, op_d;
  logic [7:0] sh_q, sh_d;
  dfpp_evt_t evt_d;
  logic evt_v_d, out_d, oe_d;

  assign rise       = ck_s2_q & ~ck_s3_q;
  assign fall       = ~ck_s2_q & ck_s3_q;
  assign o_clk_lvl  = ck_s2_q;
  assign o_data_lvl = d_s2_q;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    op_d    = op_q;
    sh_d    = sh_q;
    evt_d   = o_evt;
    evt_v_d = 1'b0;
    out_d   = o_data_out;
    oe_d    = o_data_oe;
    unique case (st_q)
      DFPP_LK_OP: if (rise) begin
        op_d  = {op_q[0], d_s2_q};
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == DFPP_OP_LAST) begin
          cnt_d = 4'h0;
          if (op_d[0] == op_d[1]) begin
            // reads: report, then shift out the selected byte
            evt_d   = '{op: dfpp_op_t'(op_d), data: 8'h00};
            evt_v_d = 1'b1;
            sh_d    = (op_d[1]) ? i_addr_byte : i_data_byte;
            st_d    = DFPP_LK_TX;
          end else begin
            st_d = DFPP_LK_RX;
          end
        end
      end
      DFPP_LK_RX: if (rise) begin
        sh_d  = {sh_q[6:0], d_s2_q};
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == DFPP_BYTE_LAST) begin
          evt_d   = '{op: dfpp_op_t'(op_q), data: sh_d};
          evt_v_d = 1'b1;
          cnt_d   = 4'h0;
          st_d    = DFPP_LK_OP;
        end
      end
      DFPP_LK_TX: if (rise && cnt_q > DFPP_BYTE_BITS) begin
        // the rise after the release ends the frame, it is not an opcode bit
        cnt_d = 4'h0;
        st_d  = DFPP_LK_OP;
      end else if (fall && cnt_q <= DFPP_BYTE_BITS) begin
        if (cnt_q == DFPP_BYTE_BITS) begin
          oe_d  = 1'b0;
          cnt_d = cnt_q + 4'h1;
        end else begin
          out_d = sh_q[7];
          oe_d  = 1'b1;
          sh_d  = {sh_q[6:0], 1'b0};
          cnt_d = cnt_q + 4'h1;
        end
      end
      default: st_d = DFPP_LK_OP;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      // link clock idles high: start the edge detector there so release shows no rise
      ck_s1_q     <= 1'b1;
      ck_s2_q     <= 1'b1;
      ck_s3_q     <= 1'b1;
      d_s1_q      <= 1'b0;
      d_s2_q      <= 1'b0;
      st_q        <= DFPP_LK_OP;
      cnt_q       <= 4'h0;
      op_q        <= 2'b00;
      sh_q        <= 8'h00;
      o_evt       <= '0;
      o_evt_valid <= 1'b0;
      o_data_out  <= 1'b0;
      o_data_oe   <= 1'b0;
    end else begin
      ck_s1_q     <= i_link_clk_pin;
      ck_s2_q     <= ck_s1_q;
      ck_s3_q     <= ck_s2_q;
      d_s1_q      <= i_link_data_pin;
      d_s2_q      <= d_s1_q;
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      op_q        <= op_d;
      sh_q        <= sh_d;
      o_evt       <= evt_d;
      o_evt_valid <= evt_v_d;
      o_data_out  <= out_d;
      o_data_oe   <= oe_d;
    end
  end

endmodule
`default_nettype wire

//--- design/dfpp_pkg.sv
// dfpp_pkg: constants and types shared by the flash programming debug port.
// assumes: a single 100 MHz system clock domain.
package dfpp_pkg;

  // link target addresses and register resets
  localparam logic [7:0] DFPP_ADDR_CTRL  = 8'h02;
  localparam logic [7:0] DFPP_ADDR_DATA  = 8'hB4;
  localparam logic [7:0] DFPP_ADDR_RST   = 8'h00;
  localparam logic [7:0] DFPP_CTRL_RST   = 8'h00;
  localparam logic [7:0] DFPP_DATA_RST   = 8'h00;

  // unlock sequence codes
  localparam logic [7:0] DFPP_UNLOCK_1ST = 8'h02;
  localparam logic [7:0] DFPP_UNLOCK_2ND = 8'h01;

  // flash command codes
  localparam logic [7:0] DFPP_CMD_BREAD  = 8'h06;
  localparam logic [7:0] DFPP_CMD_BWRITE = 8'h07;
  localparam logic [7:0] DFPP_CMD_PERASE = 8'h08;
  localparam logic [7:0] DFPP_CMD_DERASE = 8'h03;

  // link frame layout
  localparam logic [3:0] DFPP_OP_LAST    = 4'h1;
  localparam logic [3:0] DFPP_BYTE_LAST  = 4'h7;
  localparam logic [3:0] DFPP_BYTE_BITS  = 4'h8;

  typedef enum logic [1:0] {
    DFPP_OP_DREAD  = 2'b00,
    DFPP_OP_DWRITE = 2'b01,
    DFPP_OP_AWRITE = 2'b10,
    DFPP_OP_AREAD  = 2'b11
  } dfpp_op_t;

  typedef struct packed {
    dfpp_op_t   op;
    logic [7:0] data;
  } dfpp_evt_t;

  typedef enum logic [1:0] {
    DFPP_UL_LOCKED = 2'b00,
    DFPP_UL_ARMED  = 2'b01,
    DFPP_UL_OPEN   = 2'b10
  } dfpp_ul_t;

  typedef enum logic [1:0] {
    DFPP_LK_OP = 2'b00,
    DFPP_LK_RX = 2'b01,
    DFPP_LK_TX = 2'b10
  } dfpp_lk_t;

endpackage

//--- design/dfpp_top.sv
// dfpp_top: flash programming register pair behind the two-wire debug link.
// assumes: a flash engine on i_clock consumes commands and bytes; the core honours the stall.
// Functional notes
// RL1: control register at link address 0x02, reset zero
// RL2: host writes 0x02 then 0x01 to unlock
// RL3: unlocked stays until system reset
// RL4: data register at link address 0xB4, reset zero
// RL5: 0x06 block read, 0x07 block write
// RL6: 0x08 page erase, 0x03 device erase only
// RL7: core and peripherals stalled during link traffic; the code stalls only while i_halt_req or programming mode is set
// RL8: halted device lends reset and data pins
// RL9: link data commands target the selected address
`timescale 1ns/1ps
`default_nettype none
module dfpp_top import dfpp_pkg::*; (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // shared pins
  input  wire logic       i_link_clk_pin,
  input  wire logic       i_link_data_pin,
  output logic            o_data_pin_out,
  output logic            o_data_pin_oe,
  // core side
  input  wire logic       i_halt_req,
  input  wire logic       i_user_dout,
  input  wire logic       i_user_doe,
  output logic            o_core_stall_q,
  output logic            o_pin_borrowed_q,
  output logic            o_user_rst_n_q,
  output logic            o_user_din_q,
  // flash engine
  input  wire logic       i_flash_done,
  input  wire logic       i_flash_rvalid,
  input  wire logic [7:0] i_flash_rdata,
  output logic            o_flash_cmd_valid_q,
  output logic [7:0]      o_flash_cmd_q,
  output logic            o_flash_byte_valid_q,
  output logic [7:0]      o_flash_byte_q,
  output logic            o_flash_rd_ack_q,
  output logic            o_bad_cmd_q,
  output logic            o_prog_enabled_q
);

  dfpp_evt_t  evt;
  logic       evt_v, tx_out, tx_oe, ck_lvl, d_lvl;
  logic [7:0] addr_q, addr_d, ctrl_q, ctrl_d, data_q, data_d;
  dfpp_ul_t   ul_q, ul_d;
  logic       busy_q, busy_d;
  logic       wr_ctrl, wr_data, rd_data, open_d, cmd_ok;
  logic       cv_d, bv_d, ra_d, bad_d, stall_d;
  logic [7:0] cmd_d, byte_d;

  dfpp_link u_link (
    .i_clock         (i_clock),
    .i_rst           (i_rst),
    .i_link_clk_pin  (i_link_clk_pin),
    .i_link_data_pin (i_link_data_pin),
    .i_addr_byte     (addr_q),
    .i_data_byte     ((addr_q == DFPP_ADDR_CTRL) ? ctrl_q : data_q),
    .o_evt           (evt),
    .o_evt_valid     (evt_v),
    .o_data_out      (tx_out),
    .o_data_oe       (tx_oe),
    .o_clk_lvl       (ck_lvl),
    .o_data_lvl      (d_lvl)
  );

  // link data commands hit whichever target the address selects
  assign wr_ctrl = evt_v && evt.op == DFPP_OP_DWRITE && addr_q == DFPP_ADDR_CTRL; // RL9
  assign wr_data = evt_v && evt.op == DFPP_OP_DWRITE && addr_q == DFPP_ADDR_DATA; // RL9
  assign rd_data = evt_v && evt.op == DFPP_OP_DREAD && addr_q == DFPP_ADDR_DATA;
  assign cmd_ok  = evt.data == DFPP_CMD_BREAD || evt.data == DFPP_CMD_BWRITE // RL5
                || evt.data == DFPP_CMD_PERASE || evt.data == DFPP_CMD_DERASE; // RL6

  always_comb begin
    addr_d = addr_q;
    ctrl_d = ctrl_q;
    data_d = data_q;
    ul_d   = ul_q;
    if (evt_v && evt.op == DFPP_OP_AWRITE) begin
      addr_d = evt.data; // RL9
    end
    if (wr_ctrl) begin
      ctrl_d = evt.data; // RL1
      unique case (ul_q)
        DFPP_UL_LOCKED: if (evt.data == DFPP_UNLOCK_1ST) begin
          ul_d = DFPP_UL_ARMED; // RL2
        end
        DFPP_UL_ARMED: begin
          if (evt.data == DFPP_UNLOCK_2ND) begin
            ul_d = DFPP_UL_OPEN; // RL2
          end else if (evt.data != DFPP_UNLOCK_1ST) begin
            ul_d = DFPP_UL_LOCKED;
          end
        end
        DFPP_UL_OPEN: ul_d = DFPP_UL_OPEN; // RL3
        default: ul_d = DFPP_UL_LOCKED;
      endcase
    end
    if (wr_data) begin
      data_d = evt.data; // RL4
    end else if (i_flash_rvalid) begin
      data_d = i_flash_rdata;
    end
  end

  // command sequencing toward the flash engine
  assign open_d = (ul_d == DFPP_UL_OPEN);
  always_comb begin
    busy_d = busy_q;
    cv_d   = 1'b0;
    bv_d   = 1'b0;
    ra_d   = rd_data && ul_q == DFPP_UL_OPEN;
    bad_d  = 1'b0;
    cmd_d  = o_flash_cmd_q;
    byte_d = o_flash_byte_q;
    if (i_flash_done) begin
      busy_d = 1'b0;
    end
    if (wr_data && ul_q == DFPP_UL_OPEN) begin
      if (!busy_q) begin
        if (cmd_ok) begin
          cv_d   = 1'b1; // RL5
          cmd_d  = evt.data;
          busy_d = 1'b1;
        end else begin
          bad_d = 1'b1; // RL6
        end
      end else begin
        bv_d   = 1'b1;
        byte_d = evt.data;
      end
    end
    stall_d = i_halt_req || open_d; // RL7 RL3
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      addr_q               <= DFPP_ADDR_RST;
      ctrl_q               <= DFPP_CTRL_RST;
      data_q               <= DFPP_DATA_RST;
      ul_q                 <= DFPP_UL_LOCKED;
      busy_q               <= 1'b0;
      o_flash_cmd_valid_q  <= 1'b0;
      o_flash_cmd_q        <= 8'h00;
      o_flash_byte_valid_q <= 1'b0;
      o_flash_byte_q       <= 8'h00;
      o_flash_rd_ack_q     <= 1'b0;
      o_bad_cmd_q          <= 1'b0;
      o_prog_enabled_q     <= 1'b0;
      o_core_stall_q       <= 1'b0;
      o_pin_borrowed_q     <= 1'b0;
      o_user_rst_n_q       <= 1'b1;
      o_user_din_q         <= 1'b0;
      o_data_pin_out       <= 1'b0;
      o_data_pin_oe        <= 1'b0;
    end else begin
      addr_q               <= addr_d;
      ctrl_q               <= ctrl_d;
      data_q               <= data_d;
      ul_q                 <= ul_d;
      busy_q               <= busy_d;
      o_flash_cmd_valid_q  <= cv_d;
      o_flash_cmd_q        <= cmd_d;
      o_flash_byte_valid_q <= bv_d;
      o_flash_byte_q       <= byte_d;
      o_flash_rd_ack_q     <= ra_d;
      o_bad_cmd_q          <= bad_d;
      o_prog_enabled_q     <= open_d;
      o_core_stall_q       <= stall_d; // RL7
      o_pin_borrowed_q     <= stall_d; // RL8
      // borrowed pins are hidden from the user side
      o_user_rst_n_q       <= stall_d ? 1'b1 : ck_lvl; // RL8
      o_user_din_q         <= stall_d ? o_user_din_q : d_lvl; // RL8
      o_data_pin_out       <= stall_d ? tx_out : i_user_dout; // RL8
      o_data_pin_oe        <= stall_d ? tx_oe : i_user_doe; // RL8
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // checks on the register pair, the flash port and pin sharing
  a_ctrl_write: assert property (wr_ctrl |=> ctrl_q == $past(evt.data)) // RL1
    else $error("control register did not take link write");
  a_unlock_order: assert property (ul_q == DFPP_UL_LOCKED && wr_ctrl // RL2
      && evt.data == DFPP_UNLOCK_2ND |=> !o_prog_enabled_q [*2])
    else $error("unlocked without first code");
  a_unlock_sticky: assert property (o_prog_enabled_q |=> o_prog_enabled_q && o_core_stall_q) // RL3
    else $error("programming mode left without reset");
  a_data_write: assert property (wr_data |=> data_q == $past(evt.data)) // RL4
    else $error("data register did not take link write");
  a_cmd_read: assert property (wr_data && ul_q == DFPP_UL_OPEN && !busy_q // RL5
      && evt.data == DFPP_CMD_BREAD |=> o_flash_cmd_valid_q && o_flash_cmd_q == DFPP_CMD_BREAD)
    else $error("block read command not issued");
  a_cmd_invalid: assert property (wr_data && ul_q == DFPP_UL_OPEN && !busy_q && !cmd_ok // RL6
      |=> !o_flash_cmd_valid_q && o_bad_cmd_q)
    else $error("invalid command reached flash or was not flagged");
  a_locked_quiet: assert property (wr_data && ul_q != DFPP_UL_OPEN // RL2
      |=> !o_flash_cmd_valid_q && !o_flash_byte_valid_q && !o_bad_cmd_q)
    else $error("flash port active while locked");
  a_read_ack: assert property (rd_data && ul_q == DFPP_UL_OPEN // RL9
      |=> o_flash_rd_ack_q)
    else $error("data register read not acknowledged");
  a_halt_stall: assert property ($rose(i_halt_req) |-> ##1 o_core_stall_q ##0 o_pin_borrowed_q) // RL7
    else $error("halt did not stall core");
  a_pin_return: assert property (!o_pin_borrowed_q && !$past(o_pin_borrowed_q) && !$past(i_rst) // RL8
      |-> o_data_pin_oe == $past(i_user_doe))
    else $error("data pin not returned to user");
  a_addr_select: assert property (evt_v && evt.op == DFPP_OP_AWRITE // RL9
      |=> addr_q == $past(evt.data) ##1 $stable(addr_q))
    else $error("address select not stored");

  c_unlocked:  cover property (ul_q == DFPP_UL_ARMED ##1 ul_q == DFPP_UL_OPEN);
  c_erase_cmd: cover property (o_flash_cmd_valid_q && o_flash_cmd_q == DFPP_CMD_DERASE);
  c_data_byte: cover property (o_flash_byte_valid_q);
  c_link_read: cover property (evt_v && evt.op == DFPP_OP_DREAD);
  c_bad_cmd:   cover property (o_bad_cmd_q);

endmodule
`default_nettype wire

//--- sim/dfpp_host.sv
// dfpp_host: behavioural link host that clocks frames into the port.
// assumes: the bench resolves the shared data wire and feeds its level back.
`timescale 1ns/1ps
`default_nettype none
module dfpp_host import dfpp_pkg::*; (
  // link pins
  input  wire logic i_dat,
  output logic      o_clk,
  output logic      o_dat,
  output logic      o_dat_oe
);
  // clock idles high so the borrowed reset pin reads as not in reset
  initial begin
    o_clk    = 1'b1;
    o_dat    = 1'b0;
    o_dat_oe = 1'b0;
  end
  task automatic clk_level(input logic b);
    o_clk <= b;
  endtask
  // data changes while the clock is low, device samples at the rise
  task automatic put_bit(input logic b);
    o_clk    = 1'b0;
    o_dat    = b;
    o_dat_oe = 1'b1;
    #40;
    o_clk = 1'b1;
    #40;
  endtask
  task automatic frame_wr(input dfpp_op_t op, input logic [7:0] v);
    #3;
    put_bit(op[1]);
    put_bit(op[0]);
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    o_dat_oe = 1'b0;
  endtask
  // device drives each bit after a fall, sampled late in the high phase
  task automatic frame_rd(input dfpp_op_t op, output logic [7:0] v);
    #3;
    put_bit(op[1]);
    put_bit(op[0]);
    o_dat_oe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      o_clk = 1'b0;
      #40;
      o_clk = 1'b1;
      #35;
      v[i] = i_dat;
      #5;
    end
    o_clk = 1'b0;
    #40;
    o_clk = 1'b1;
    #40;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    frame_wr(DFPP_OP_AWRITE, a);
    frame_wr(DFPP_OP_DWRITE, v);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    frame_wr(DFPP_OP_AWRITE, a);
    frame_rd(DFPP_OP_DREAD, v);
  endtask
  task automatic unlock;
    wr_reg(DFPP_ADDR_CTRL, DFPP_UNLOCK_1ST);
    frame_wr(DFPP_OP_DWRITE, DFPP_UNLOCK_2ND);
  endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// testbench: runs the flash programming port through the link host model.
// assumes: 100 MHz system clock; the host model paces the link at 80 ns.
`timescale 1ns/1ps
`default_nettype none
module testbench import dfpp_pkg::*; ;
  logic       i_clock, i_rst, i_halt_req, i_user_dout, i_user_doe;
  logic       i_flash_done, i_flash_rvalid;
  logic [7:0] i_flash_rdata, o_flash_cmd_q, o_flash_byte_q, got, v, last_cmd, last_byte;
  logic       o_data_pin_out, o_data_pin_oe, o_core_stall_q, o_pin_borrowed_q;
  logic       o_user_rst_n_q, o_user_din_q, o_flash_cmd_valid_q, o_flash_byte_valid_q;
  logic       o_flash_rd_ack_q, o_bad_cmd_q, o_prog_enabled_q;
  logic       h_clk, h_dat, h_oe, wire_lvl, last_q;
  int         fail_count, n_tests, cyc, n_cmd, n_bad, n_ack, c;
  logic [7:0] codes [4] = '{DFPP_CMD_BREAD, DFPP_CMD_BWRITE, DFPP_CMD_PERASE, DFPP_CMD_DERASE};

  // undriven wire shows the inverse of its last level
  assign wire_lvl = o_data_pin_oe ? o_data_pin_out : (h_oe ? h_dat : ~last_q);

  dfpp_host i_host (.i_dat(wire_lvl), .o_clk(h_clk), .o_dat(h_dat), .o_dat_oe(h_oe));

  dfpp_top i_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_link_clk_pin(h_clk), .i_link_data_pin(wire_lvl),
    .o_data_pin_out(o_data_pin_out), .o_data_pin_oe(o_data_pin_oe), .i_halt_req(i_halt_req),
    .i_user_dout(i_user_dout), .i_user_doe(i_user_doe), .o_core_stall_q(o_core_stall_q),
    .o_pin_borrowed_q(o_pin_borrowed_q), .o_user_rst_n_q(o_user_rst_n_q),
    .o_user_din_q(o_user_din_q), .i_flash_done(i_flash_done), .i_flash_rvalid(i_flash_rvalid),
    .i_flash_rdata(i_flash_rdata), .o_flash_cmd_valid_q(o_flash_cmd_valid_q),
    .o_flash_cmd_q(o_flash_cmd_q), .o_flash_byte_valid_q(o_flash_byte_valid_q),
    .o_flash_byte_q(o_flash_byte_q), .o_flash_rd_ack_q(o_flash_rd_ack_q),
    .o_bad_cmd_q(o_bad_cmd_q), .o_prog_enabled_q(o_prog_enabled_q));

  initial i_clock = 1'b0;
  always #5 i_clock = ~i_clock;

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // flash port monitor and hang guard
  always @(posedge i_clock) begin
    if (o_data_pin_oe || h_oe) last_q <= wire_lvl;
    if (o_flash_cmd_valid_q === 1'b1) n_cmd <= n_cmd + 1;
    if (o_flash_cmd_valid_q === 1'b1) last_cmd <= o_flash_cmd_q;
    if (o_flash_byte_valid_q === 1'b1) last_byte <= o_flash_byte_q;
    if (o_bad_cmd_q === 1'b1) n_bad <= n_bad + 1;
    if (o_flash_rd_ack_q === 1'b1) n_ack <= n_ack + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic flash_pulse(input logic rd, input logic [7:0] d);
    @(posedge i_clock);
    i_flash_done   <= ~rd;
    i_flash_rvalid <= rd;
    i_flash_rdata  <= d;
    @(posedge i_clock);
    i_flash_done   <= 1'b0;
    i_flash_rvalid <= 1'b0;
  endtask

  initial begin
    {i_rst, i_halt_req, i_user_dout, i_user_doe, i_flash_done, i_flash_rvalid} = 6'h20;
    i_flash_rdata = 8'h00;
    last_q = 1'b0;
    {fail_count, n_tests, cyc, n_cmd, n_bad, n_ack} = '0;
    void'($urandom(89509));
    wait_clk(8);
    i_rst <= 1'b0;
    wait_clk(3);
    // running: user logic owns both pins
    v = 8'($urandom);
    i_user_doe  <= 1'b1;
    i_user_dout <= v[0];
    wait_clk(5);
    chk({7'h00, o_data_pin_oe}, 8'h01);
    chk({7'h00, o_user_din_q}, {7'h00, v[0]});
    chk({7'h00, o_core_stall_q}, 8'h00);
    i_host.clk_level(1'b0);
    wait_clk(4);
    chk({7'h00, o_user_rst_n_q}, 8'h00);
    i_host.clk_level(1'b1);
    // a pulse on the system reset restarts the device and its link framing
    i_rst <= 1'b1;
    wait_clk(2);
    i_rst <= 1'b0;
    wait_clk(3);
    chk({7'h00, o_user_rst_n_q}, 8'h01);
    // halt lends the pins to the link
    i_halt_req <= 1'b1;
    wait_clk(4);
    chk({6'h00, o_core_stall_q, o_pin_borrowed_q}, 8'h03);
    chk({7'h00, o_data_pin_oe}, 8'h00);
    i_host.rd_reg(DFPP_ADDR_CTRL, got);
    chk(got, DFPP_CTRL_RST);
    i_host.rd_reg(DFPP_ADDR_DATA, got);
    chk(got, DFPP_DATA_RST);
    i_host.frame_rd(DFPP_OP_AREAD, got);
    chk(got, DFPP_ADDR_DATA);
    i_host.frame_wr(DFPP_OP_DWRITE, DFPP_CMD_BREAD);
    i_host.frame_rd(DFPP_OP_DREAD, got);
    chk(got, DFPP_CMD_BREAD);
    chk(8'(n_cmd), 8'h00);
    // wrong second code relocks the sequence
    i_host.wr_reg(DFPP_ADDR_CTRL, DFPP_UNLOCK_1ST);
    i_host.frame_wr(DFPP_OP_DWRITE, 8'h05);
    i_host.frame_wr(DFPP_OP_DWRITE, DFPP_UNLOCK_2ND);
    wait_clk(4);
    chk({7'h00, o_prog_enabled_q}, 8'h00);
    i_host.unlock();
    wait_clk(4);
    chk({7'h00, o_prog_enabled_q}, 8'h01);
    i_halt_req <= 1'b0;
    v = 8'($urandom);
    i_host.frame_wr(DFPP_OP_DWRITE, v);
    i_host.frame_rd(DFPP_OP_DREAD, got);
    chk(got, v);
    chk({6'h00, o_core_stall_q, o_prog_enabled_q}, 8'h03);
    i_host.frame_wr(DFPP_OP_AWRITE, DFPP_ADDR_DATA);
    for (int k = 0; k < 4; k++) begin
      c = n_cmd;
      i_host.frame_wr(DFPP_OP_DWRITE, codes[k]);
      wait_clk(4);
      chk(8'(n_cmd - c), 8'h01);
      chk(last_cmd, codes[k]);
      v = 8'($urandom);
      i_host.frame_wr(DFPP_OP_DWRITE, v);
      wait_clk(4);
      chk(last_byte, v);
      flash_pulse(1'b0, 8'h00);
    end
    v = 8'($urandom);
    if (v == 8'h03 || v == 8'h06 || v == 8'h07 || v == 8'h08) v = 8'hFF;
    c = n_cmd + 256 * n_bad;
    i_host.frame_wr(DFPP_OP_DWRITE, v);
    wait_clk(4);
    chk(8'(n_cmd + 256 * n_bad - c), 8'h00);
    chk(8'(n_bad), 8'h01);
    v = 8'($urandom);
    flash_pulse(1'b1, v);
    i_host.frame_rd(DFPP_OP_DREAD, got);
    chk(got, v);
    chk(8'(n_ack), 8'h01);
    // only a system reset leaves programming mode
    i_rst <= 1'b1;
    wait_clk(2);
    i_rst <= 1'b0;
    wait_clk(3);
    chk({6'h00, o_core_stall_q, o_prog_enabled_q}, 8'h00);
    i_halt_req <= 1'b1;
    wait_clk(4);
    i_host.rd_reg(DFPP_ADDR_CTRL, got);
    chk(got, DFPP_CTRL_RST);
    report_and_stop();
  end
endmodule
`default_nettype wire
